// file: design/flash_sr_pkg.sv
package flash_sr_pkg;

  localparam int DQ_W = 16;
  localparam int ADDR_W = 16;

  // Command codes on the low data byte
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_IDENT   = 8'h90;
  localparam logic [7:0] CMD_PROG_A       = 8'h40;
  localparam logic [7:0] CMD_PROG_B       = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
  localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
  localparam logic [7:0] CMD_LOCK         = 8'h01;
  localparam logic [7:0] CMD_LOCK_DOWN    = 8'h2f;
  localparam logic [7:0] CMD_CONFIG       = 8'h03;

  // Status fields
  localparam int SR_READY = 7;
  localparam int SR_ESUSP = 6;
  localparam int SR_ERR_HI = 5;
  localparam int SR_ERR_LO = 4;
  localparam int SR_VPP = 3;
  localparam int SR_PSUSP = 2;
  localparam int SR_LOCK = 1;
  localparam int SR_BULK = 0;
  localparam logic [7:0] SR_DEFAULT = 8'h80;
  localparam logic [7:0] SR_UPPER_LANES = 8'h00;
  localparam logic [1:0] ERR_NONE = 2'b00;
  localparam logic [1:0] ERR_PROG = 2'b01;
  localparam logic [1:0] ERR_ERASE = 2'b10;
  localparam logic [1:0] ERR_SEQ = 2'b11;

  // Read configuration fields
  localparam logic [7:0] RCR_IDENT_OFFSET = 8'h05;
  localparam int RCR_MODE = 15;
  localparam int RCR_LAT_HI = 14;
  localparam int RCR_LAT_LO = 11;
  localparam int RCR_WAIT_POL = 10;
  localparam int RCR_WAIT_DLY = 8;
  localparam int RCR_EDGE = 6;
  localparam int RCR_WRAP = 3;
  localparam int RCR_BL_HI = 2;
  localparam int RCR_BL_LO = 0;
  localparam logic [15:0] RCR_RESET = 16'hf94f;
  localparam logic [15:0] RCR_WRITABLE = 16'hfd4f;
  localparam logic [3:0] LAT_MIN = 4'h2;
  localparam logic [2:0] BL_4 = 3'b001;
  localparam logic [2:0] BL_8 = 3'b010;
  localparam logic [2:0] BL_16 = 3'b011;
  localparam logic [2:0] BL_CONT = 3'b111;
  localparam logic [4:0] BEATS_4 = 5'h04;
  localparam logic [4:0] BEATS_8 = 5'h08;
  localparam logic [4:0] BEATS_16 = 5'h10;

  typedef enum logic [1:0] {
    MODE_ARRAY  = 2'b00,
    MODE_STATUS = 2'b01,
    MODE_IDENT  = 2'b10
  } read_mode_e;

  typedef enum logic [1:0] {
    SETUP_NONE  = 2'b00,
    SETUP_PROG  = 2'b01,
    SETUP_ERASE = 2'b10,
    SETUP_LOCK  = 2'b11
  } setup_e;

  typedef enum logic [1:0] {
    B_IDLE = 2'b00,
    B_LAT  = 2'b01,
    B_DATA = 2'b10,
    B_DONE = 2'b11
  } burst_e;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              adv_n;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   dq;
  } pins_s;

  localparam pins_s PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, adv_n: 1'b1,
                                  addr: 16'h0000, dq: 16'h0000};

endpackage

// file: design/flash_status_and_read_config.sv
// Operation
// R1: After read-status, program, erase or lock sequences, reads return status until next command.
// R2: Status reads drive status on low byte and zeros on upper byte.
// R3: Asynchronous reads latch fresh status when the access starts and hold it.
// R4: Host toggles chip enable or address valid to refresh status in burst mode.
// R5: Nonarray reads: only first page word valid; bursts repeat word until length met.
// R6: Bit 7 reads 0 while an algorithm runs, 1 when ready.
// R7: Bits 6 and 2 show erase and program suspend respectively.
// R8: Bits 5:4 encode success, program, erase or sequence error; errors abort.
// R9: Bit 3 flags low program supply during program or erase.
// R10: Bit 1 flags program or erase attempted on a locked block; aborts.
// R11: Bit 0 shows bulk factory load still in progress.
// R12: Status default value is 0x80.
// R13: Sequence error in erase suspend keeps bits 7,5,4 set after resume.
// R14: Host clears status after errors and before resuming erase.
// R15: Bits 7,6,2 follow device; bits 5:3 and 1 sticky until clear-status.
// R16: Reset restores status to its default.
// R17: Configuration written only by configure command; read at identifier offset 5.
// R18: Bit 15 selects burst (0) or page (1) reads; defaults asynchronous.
// R19: Bits 14:11 latency code 2..15, default 15, codes 0 and 1 reserved.
// R20: Bit 10 sets wait polarity; bit 8 deasserts wait one cycle early.
// R21: Bit 6 selects sample edge, default rising; bits 9,7,5,4 fixed zero. Bit 6 is only stored; the burst side always uses the rising edge.
// R22: Bits 2:0 burst length 4/8/16/continuous; bit 3 selects no wrap. Bit 3 is only stored; the burst side never reads it.
// R23: Writes of reserved bits or reserved latency or length codes are ignored.
`timescale 1ns/100ps
`default_nettype none

module flash_status_and_read_config (
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_link_clk,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_adv_n,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_dq_in,
  input  wire logic        i_busy,
  input  wire logic        i_erase_susp,
  input  wire logic        i_prog_susp,
  input  wire logic        i_bulk_loading,
  input  wire logic        i_vpp_low,
  input  wire logic        i_prog_err,
  input  wire logic        i_erase_err,
  input  wire logic        i_lock_hit,
  input  wire logic [15:0] i_ident_word,
  output logic      [15:0] o_dq_out,
  output logic             o_dq_oe,
  output logic      [15:0] o_sdq_out,
  output logic             o_sdq_oe,
  output logic             o_wait,
  output logic             o_wait_oe,
  output logic      [15:0] o_read_config,
  output logic             o_prog_start,
  output logic             o_erase_start,
  output logic             o_lock_start,
  output logic             o_abort
);

  typedef struct packed {
    flash_sr_pkg::pins_s      s1;
    flash_sr_pkg::pins_s      s2;
    flash_sr_pkg::pins_s      s3;
    flash_sr_pkg::pins_s      filt;
    flash_sr_pkg::read_mode_e mode;
    flash_sr_pkg::setup_e     setup;
    logic [1:0]               err;
    logic                     vpp;
    logic                     lock;
    logic [15:0]              read_configuration;
    logic [15:0]              word;
    logic                     word_tog;
    logic [15:0]              dq_out;
    logic                     dq_oe;
    logic                     prog_start;
    logic                     erase_start;
    logic                     lock_start;
    logic                     abort;
  } ref_s;

  typedef struct packed {
    logic [16:0]            cfg1;
    logic [16:0]            cfg2;
    logic                   tog1;
    logic                   tog2;
    logic                   tog3;
    logic [15:0]            word;
    flash_sr_pkg::burst_e   state;
    logic [3:0]             cnt;
    logic [4:0]             beats;
    logic [15:0]            sdq_out;
    logic                   sdq_oe;
    logic                   wait_o;
    logic                   wait_oe;
  } link_s;

  ref_s  q;
  ref_s  d;
  link_s lq;
  link_s ld;

  flash_sr_pkg::pins_s pins_now;
  logic [7:0]          status;
  logic                wr_stb;
  logic [7:0]          cmd;
  logic                rd_now_d;
  logic                rd_now_q;
  logic                access_start;
  logic                sync_refresh;
  logic                seq_err;
  logic                clr;
  logic [1:0]          err_set;
  logic                vpp_set;
  logic [15:0]         rcr_new;

  assign pins_now = '{ce_n: i_ce_n, oe_n: i_oe_n, we_n: i_we_n, adv_n: i_adv_n,
                      addr: i_addr, dq: i_dq_in};

  // Live bits come straight from the engine, sticky bits from flops
  assign status = {~i_busy, i_erase_susp, q.err, q.vpp,               // [R6] [R7] [R15]
                   i_prog_susp, q.lock, i_bulk_loading};              // [R11]

  always_comb begin
    d = q;
    seq_err = 1'b0;
    clr = 1'b0;
    rcr_new = q.read_configuration;
    d.prog_start = 1'b0;
    d.erase_start = 1'b0;
    d.lock_start = 1'b0;

    // Three-stage pin capture; a bit changes once stages two and three agree
    d.s1 = pins_now;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.filt = (q.s2 & q.s3) | (q.filt & (q.s2 | q.s3));

    wr_stb = ~q.filt.we_n & d.filt.we_n & ~q.filt.ce_n;
    cmd = q.filt.dq[7:0];

    if (wr_stb) begin
      unique case (q.setup)
        flash_sr_pkg::SETUP_PROG: begin
          d.setup = flash_sr_pkg::SETUP_NONE;
          d.mode = flash_sr_pkg::MODE_STATUS;                          // [R1]
          d.prog_start = 1'b1;
        end
        flash_sr_pkg::SETUP_ERASE: begin
          d.setup = flash_sr_pkg::SETUP_NONE;
          d.mode = flash_sr_pkg::MODE_STATUS;                          // [R1]
          if (cmd == flash_sr_pkg::CMD_CONFIRM) begin
            d.erase_start = 1'b1;
          end else begin
            seq_err = 1'b1;
          end
        end
        flash_sr_pkg::SETUP_LOCK: begin
          d.setup = flash_sr_pkg::SETUP_NONE;
          if (cmd == flash_sr_pkg::CMD_CONFIG) begin
            // Field data rides on the address lines
            rcr_new = q.filt.addr & flash_sr_pkg::RCR_WRITABLE;        // [R17] [R21] [R23]
            if (rcr_new[flash_sr_pkg::RCR_LAT_HI:flash_sr_pkg::RCR_LAT_LO]
                < flash_sr_pkg::LAT_MIN) begin
              rcr_new[flash_sr_pkg::RCR_LAT_HI:flash_sr_pkg::RCR_LAT_LO] =
                q.read_configuration[flash_sr_pkg::RCR_LAT_HI:flash_sr_pkg::RCR_LAT_LO]; // [R19] [R23]
            end
            if (!(rcr_new[flash_sr_pkg::RCR_BL_HI:flash_sr_pkg::RCR_BL_LO]
                  inside {flash_sr_pkg::BL_4, flash_sr_pkg::BL_8,
                          flash_sr_pkg::BL_16, flash_sr_pkg::BL_CONT})) begin
              rcr_new[flash_sr_pkg::RCR_BL_HI:flash_sr_pkg::RCR_BL_LO] =
                q.read_configuration[flash_sr_pkg::RCR_BL_HI:flash_sr_pkg::RCR_BL_LO];   // [R22] [R23]
            end
            d.read_configuration = rcr_new;
          end else if (cmd == flash_sr_pkg::CMD_LOCK || cmd == flash_sr_pkg::CMD_CONFIRM ||
                       cmd == flash_sr_pkg::CMD_LOCK_DOWN) begin
            d.mode = flash_sr_pkg::MODE_STATUS;                        // [R1]
            d.lock_start = 1'b1;
          end else begin
            seq_err = 1'b1;
            d.mode = flash_sr_pkg::MODE_STATUS;
          end
        end
        default: begin
          unique case (cmd)
            flash_sr_pkg::CMD_READ_ARRAY:   d.mode = flash_sr_pkg::MODE_ARRAY;
            flash_sr_pkg::CMD_READ_STATUS:  d.mode = flash_sr_pkg::MODE_STATUS;  // [R1]
            flash_sr_pkg::CMD_READ_IDENT:   d.mode = flash_sr_pkg::MODE_IDENT;
            flash_sr_pkg::CMD_CLEAR_STATUS: clr = 1'b1;                // [R15]
            flash_sr_pkg::CMD_PROG_A,
            flash_sr_pkg::CMD_PROG_B:       d.setup = flash_sr_pkg::SETUP_PROG;
            flash_sr_pkg::CMD_ERASE_SETUP:  d.setup = flash_sr_pkg::SETUP_ERASE;
            flash_sr_pkg::CMD_LOCK_SETUP:   d.setup = flash_sr_pkg::SETUP_LOCK;
            default: begin
              seq_err = 1'b1;
              d.mode = flash_sr_pkg::MODE_STATUS;
            end
          endcase
        end
      endcase
    end

    // Sticky error bits: a set in the clearing cycle survives
    err_set = {i_erase_err | seq_err, i_prog_err | seq_err};          // [R8] [R13]
    vpp_set = i_vpp_low & i_busy;                                      // [R9]
    d.err = (clr ? flash_sr_pkg::ERR_NONE : q.err) | err_set;          // [R15] [R13]
    d.vpp = (clr ? 1'b0 : q.vpp) | vpp_set;                            // [R9] [R15]
    d.lock = (clr ? 1'b0 : q.lock) | i_lock_hit;                       // [R10] [R15]
    d.abort = (|err_set) | vpp_set | i_lock_hit;                       // [R8] [R10]

    // Word capture for nonarray reads
    rd_now_q = ~q.filt.ce_n & ~q.filt.oe_n;
    rd_now_d = ~d.filt.ce_n & ~d.filt.oe_n;
    access_start = rd_now_d & ~rd_now_q;
    sync_refresh = (q.filt.ce_n & ~d.filt.ce_n) | (q.filt.adv_n & ~d.filt.adv_n);
    if ((q.read_configuration[flash_sr_pkg::RCR_MODE] && access_start) ||             // [R3]
        (!q.read_configuration[flash_sr_pkg::RCR_MODE] && sync_refresh)) begin        // [R4]
      d.word_tog = ~q.word_tog;
      if (q.mode == flash_sr_pkg::MODE_IDENT) begin
        d.word = (d.filt.addr[7:0] == flash_sr_pkg::RCR_IDENT_OFFSET) ?
                 q.read_configuration : i_ident_word;                                 // [R17]
      end else begin
        d.word = {flash_sr_pkg::SR_UPPER_LANES, status};               // [R2]
      end
    end

    // Page mode drive: captured word held for the whole access
    d.dq_out = q.word;                                                 // [R3] [R5]
    d.dq_oe = rd_now_q & q.read_configuration[flash_sr_pkg::RCR_MODE] &
              (q.mode != flash_sr_pkg::MODE_ARRAY);
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;                                                         // [R12] [R16]
      q.s1 <= flash_sr_pkg::PINS_IDLE;
      q.s2 <= flash_sr_pkg::PINS_IDLE;
      q.s3 <= flash_sr_pkg::PINS_IDLE;
      q.filt <= flash_sr_pkg::PINS_IDLE;
      q.read_configuration <= flash_sr_pkg::RCR_RESET;                                // [R18]
    end else begin
      q <= d;
    end
  end

  // Burst side on the host clock
  logic [4:0] beat_limit;
  logic       lk_cont;
  logic       lk_go;

  always_comb begin
    ld = lq;
    ld.cfg1 = {q.mode != flash_sr_pkg::MODE_ARRAY, q.read_configuration};
    ld.cfg2 = lq.cfg1;
    ld.tog1 = q.word_tog;
    ld.tog2 = lq.tog1;
    ld.tog3 = lq.tog2;
    if (lq.tog2 != lq.tog3) begin
      ld.word = q.word;
    end

    unique case (lq.cfg2[flash_sr_pkg::RCR_BL_HI:flash_sr_pkg::RCR_BL_LO])
      flash_sr_pkg::BL_4:  beat_limit = flash_sr_pkg::BEATS_4;
      flash_sr_pkg::BL_8:  beat_limit = flash_sr_pkg::BEATS_8;
      default:             beat_limit = flash_sr_pkg::BEATS_16;
    endcase
    lk_cont = lq.cfg2[flash_sr_pkg::RCR_BL_HI:flash_sr_pkg::RCR_BL_LO] ==
              flash_sr_pkg::BL_CONT;
    lk_go = ~i_ce_n & ~i_adv_n & ~lq.cfg2[flash_sr_pkg::RCR_MODE] & lq.cfg2[16];

    unique case (lq.state)
      flash_sr_pkg::B_IDLE: begin
        if (lk_go) begin
          ld.state = flash_sr_pkg::B_LAT;
          ld.cnt = lq.cfg2[flash_sr_pkg::RCR_LAT_HI:flash_sr_pkg::RCR_LAT_LO];  // [R19]
        end
      end
      flash_sr_pkg::B_LAT: begin
        ld.cnt = lq.cnt - 4'h1;
        if (lq.cnt == 4'h1) begin
          ld.state = flash_sr_pkg::B_DATA;
          ld.beats = 5'h00;
        end
      end
      flash_sr_pkg::B_DATA: begin
        ld.beats = lq.beats + 5'h01;
        if (!lk_cont && lq.beats == beat_limit - 5'h01) begin         // [R22]
          ld.state = flash_sr_pkg::B_DONE;
        end
      end
      default: ;
    endcase
    if (i_ce_n) begin
      ld.state = flash_sr_pkg::B_IDLE;
    end else if (lq.state != flash_sr_pkg::B_IDLE && !i_adv_n && lk_go) begin
      ld.state = flash_sr_pkg::B_LAT;                                  // [R4]
      ld.cnt = lq.cfg2[flash_sr_pkg::RCR_LAT_HI:flash_sr_pkg::RCR_LAT_LO];
    end

    // Same word on every beat until the length is met
    ld.sdq_out = lq.word;                                              // [R5]
    ld.sdq_oe = (ld.state == flash_sr_pkg::B_DATA) & ~i_oe_n;
    ld.wait_oe = ~i_ce_n & ~i_oe_n;
    // Asserted level equals the polarity bit
    ld.wait_o = lq.cfg2[flash_sr_pkg::RCR_WAIT_POL] ^                  // [R20]
                ~((ld.state == flash_sr_pkg::B_LAT) &&
                  !(lq.cfg2[flash_sr_pkg::RCR_WAIT_DLY] && ld.cnt == 4'h1));  // [R20]
  end

  always_ff @(posedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lq <= '0;
      lq.cfg1 <= {1'b0, flash_sr_pkg::RCR_RESET};
      lq.cfg2 <= {1'b0, flash_sr_pkg::RCR_RESET};
      lq.wait_o <= 1'b1;
    end else begin
      lq <= ld;
    end
  end

  assign o_dq_out = q.dq_out;
  assign o_dq_oe = q.dq_oe;
  assign o_read_config = q.read_configuration;
  assign o_prog_start = q.prog_start;
  assign o_erase_start = q.erase_start;
  assign o_lock_start = q.lock_start;
  assign o_abort = q.abort;
  assign o_sdq_out = lq.sdq_out;
  assign o_sdq_oe = lq.sdq_oe;
  assign o_wait = lq.wait_o;
  assign o_wait_oe = lq.wait_oe;

endmodule

`default_nettype wire

// file: testbench/flash_status_and_read_config_properties.sv
`timescale 1ns/100ps
`default_nettype none
module flash_status_and_read_config_properties (
  input wire logic        i_ref_clk,
  input wire logic        i_nrst,
  input wire logic        i_link_clk,
  input wire logic        i_ce_n,
  input wire logic        i_we_n,
  input wire logic        i_prog_err,
  input wire logic        i_lock_hit,
  input wire logic        o_dq_oe,
  input wire logic        o_sdq_oe,
  input wire logic        o_wait,
  input wire logic        o_wait_oe,
  input wire logic [15:0] o_read_config,
  input wire logic        o_abort
);
  a_cfg_fixed_zero: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (o_read_config & 16'h02b0) == 16'h0000) else $error("reserved config bit set");
  a_latency_legal: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_read_config[14:12] != 3'h0) else $error("reserved latency code held");
  a_burst_legal: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_read_config[2:0] inside {3'h1, 3'h2, 3'h3, 3'h7}) else $error("reserved length held");
  a_cfg_write_only: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    i_we_n [*8] |=> $stable(o_read_config)) else $error("config changed without write");
  a_prog_err_abort: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    i_prog_err |-> ##[1:3] o_abort) else $error("program error without abort");
  a_lock_hit_abort: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    i_lock_hit |-> ##[1:3] o_abort) else $error("locked block without abort");
  a_idle_no_drive: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    i_ce_n [*8] |-> !o_dq_oe) else $error("page drive while deselected");
  a_burst_sync_only: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    o_sdq_oe |-> !o_read_config[15]) else $error("burst drive in page mode");
  a_wait_data_level: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    o_sdq_oe && o_wait_oe |-> o_wait == !o_read_config[10]) else $error("wait asserted on data");
endmodule
bind flash_status_and_read_config flash_status_and_read_config_properties u_props (
  .i_ref_clk, .i_nrst, .i_link_clk, .i_ce_n, .i_we_n, .i_prog_err, .i_lock_hit,
  .o_dq_oe, .o_sdq_oe, .o_wait, .o_wait_oe, .o_read_config, .o_abort);
`default_nettype wire

// file: testbench/host_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
  input  wire logic        i_ref_clk,
  input  wire logic [15:0] i_dq_bus,
  input  wire logic        i_dq_valid,
  input  wire logic        i_sdq_valid,
  input  wire logic        i_wait,
  input  wire logic        i_wait_oe,
  output logic             o_link_clk,
  output logic             o_ce_n,
  output logic             o_oe_n,
  output logic             o_we_n,
  output logic             o_adv_n,
  output logic      [15:0] o_addr,
  output logic      [15:0] o_dq,
  output logic             o_dq_drive
);
  logic lk_run;
  initial begin
    {o_link_clk, lk_run, o_dq_drive} = 3'h0;
    {o_ce_n, o_oe_n, o_we_n, o_adv_n} = 4'hf;
    {o_addr, o_dq} = 32'h0000_0000;
  end
  // Link clock only runs inside a burst frame
  always #6 o_link_clk = lk_run ? ~o_link_clk : 1'b0;
  task automatic cycles(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  task automatic bus_write(input logic [15:0] a, input logic [7:0] c);
    cycles(1);
    {o_ce_n, o_we_n, o_dq_drive} = 3'b001;
    o_addr = a;
    o_dq = {8'h00, c};
    cycles(6);
    o_we_n = 1'b1;
    cycles(6);
    {o_ce_n, o_dq_drive} = 2'b10;
  endtask
  task automatic clear_status();
    cycles(1500);
    bus_write(16'h0000, flash_sr_pkg::CMD_CLEAR_STATUS);
  endtask
  task automatic page_read(input logic [15:0] a, output logic [15:0] d0, output logic [15:0] d1);
    int n;
    cycles(1);
    {o_ce_n, o_oe_n} = 2'b00;
    o_addr = a;
    n = 0;
    do begin
      cycles(1);
      n++;
    end while (!i_dq_valid && n < 20);
    d0 = i_dq_bus;
    cycles(5);
    d1 = i_dq_bus;
    {o_ce_n, o_oe_n} = 2'b11;
    cycles(6);
  endtask
  task automatic burst_read(input logic wp, output int lat, output int waits, output int beats,
                            output logic [15:0] w, output logic rep);
    int e;
    {lat, waits, beats, e} = {32'd0, 32'd0, 32'd0, 32'd0};
    {w, rep} = 17'h00001;
    cycles(1);
    // Clock runs a few edges first so the link side sees the current configuration
    lk_run = 1'b1;
    repeat (3) @(negedge o_link_clk);
    {o_ce_n, o_oe_n, o_adv_n} = 3'b000;
    @(negedge o_link_clk);
    o_adv_n = 1'b1;
    while (e < 40 && (beats == 0 || i_sdq_valid)) begin
      if (i_wait_oe && i_wait == wp) waits++;
      if (i_sdq_valid) begin
        if (beats == 0) begin
          lat = e;
          w = i_dq_bus;
        end
        if (i_dq_bus !== w) rep = 1'b0;
        beats++;
      end
      e++;
      @(negedge o_link_clk);
    end
    {o_ce_n, o_oe_n} = 2'b11;
    repeat (4) @(negedge o_link_clk);
    lk_run = 1'b0;
    cycles(4);
  endtask
endmodule
`default_nettype wire

// file: testbench/flash_status_and_read_config_tb.sv
`timescale 1ns/100ps
`default_nettype none
module flash_status_and_read_config_tb;
  logic        i_ref_clk, i_nrst, busy, esusp, psusp, bulk, vpp_low, prog_err, erase_err;
  logic        lock_hit, dq_oe, sdq_oe, wt, wt_oe, link_clk, ce_n, oe_n, we_n, adv_n;
  logic        host_drive, rep, vpp_f, lock_f;
  logic [1:0]  err_code;
  logic [15:0] ident, dq_bus, dq_last, d0, d1, cfg, w, ex, v, dq_out, sdq_out, read_cfg;
  logic [15:0] addr, host_dq;
  int          fails, checks_done, seed, lat, waits, beats;
  logic [2:0]  bl_tab[4] = '{3'h1, 3'h2, 3'h3, 3'h7};

  // Released bus shows a changing pattern, never the last value
  assign dq_bus = dq_oe ? dq_out : sdq_oe ? sdq_out : host_drive ? host_dq : ~dq_last;
  always @(posedge i_ref_clk) dq_last <= dq_bus;
  always #5 i_ref_clk = ~i_ref_clk;

  flash_status_and_read_config u_dut (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_link_clk(link_clk), .i_ce_n(ce_n),
    .i_oe_n(oe_n), .i_we_n(we_n), .i_adv_n(adv_n), .i_addr(addr), .i_dq_in(dq_bus),
    .i_busy(busy), .i_erase_susp(esusp), .i_prog_susp(psusp), .i_bulk_loading(bulk),
    .i_vpp_low(vpp_low), .i_prog_err(prog_err), .i_erase_err(erase_err),
    .i_lock_hit(lock_hit), .i_ident_word(ident), .o_dq_out(dq_out), .o_dq_oe(dq_oe),
    .o_sdq_out(sdq_out), .o_sdq_oe(sdq_oe), .o_wait(wt), .o_wait_oe(wt_oe),
    .o_read_config(read_cfg), .o_prog_start(), .o_erase_start(), .o_lock_start(),
    .o_abort());

  host_bus_model u_host (
    .i_ref_clk(i_ref_clk), .i_dq_bus(dq_bus), .i_dq_valid(dq_oe), .i_sdq_valid(sdq_oe),
    .i_wait(wt), .i_wait_oe(wt_oe), .o_link_clk(link_clk), .o_ce_n(ce_n), .o_oe_n(oe_n),
    .o_we_n(we_n), .o_adv_n(adv_n), .o_addr(addr), .o_dq(host_dq), .o_dq_drive(host_drive));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  function automatic logic [15:0] exp_status();
    return {8'h00, ~busy, esusp, err_code, vpp_f, psusp, lock_f, bulk};
  endfunction
  function automatic logic [15:0] next_cfg(input logic [15:0] old, input logic [15:0] nv);
    logic [15:0] n;
    n = nv & 16'hfd4f;
    if (nv[14:12] == 3'h0) n[14:11] = old[14:11];
    if (!(nv[2:0] inside {3'h1, 3'h2, 3'h3, 3'h7})) n[2:0] = old[2:0];
    return n;
  endfunction
  task automatic pulse(ref logic s);
    @(negedge i_ref_clk) s = 1'b1;
    @(negedge i_ref_clk) s = 1'b0;
  endtask
  task automatic configure(input logic [15:0] nv);
    u_host.bus_write(16'h0000, flash_sr_pkg::CMD_LOCK_SETUP);
    u_host.bus_write(nv, flash_sr_pkg::CMD_CONFIG);
    cfg = next_cfg(cfg, nv);
    check("read config", read_cfg, cfg);
  endtask
  task automatic read_status();
    u_host.bus_write(16'h0000, flash_sr_pkg::CMD_READ_STATUS);
    u_host.page_read(16'h0000, d0, d1);
    check("status", d0, exp_status());
  endtask

  initial begin
    #1000000;
    fails++;
    close_out();
  end

  initial begin
    seed = 63;
    {i_ref_clk, i_nrst, busy, esusp, psusp, bulk, vpp_low, prog_err, erase_err} = 9'h000;
    {lock_hit, err_code, vpp_f, lock_f, fails, checks_done} = '0;
    {ident, dq_last, cfg} = {16'h0000, 16'h0000, 16'hf94f};
    repeat (10) @(negedge i_ref_clk);
    i_nrst = 1'b1;
    check("config default", read_cfg, cfg);
    ident = 16'($random(seed));
    u_host.bus_write(16'h0000, flash_sr_pkg::CMD_READ_IDENT);
    u_host.page_read(16'h0005, d0, d1);
    check("ident config", d0, cfg);
    u_host.page_read(16'h0003, d0, d1);
    check("ident word", d0, ident);
    read_status();
    for (int i = 0; i < 8; i++) begin
      {busy, esusp, psusp, bulk} = 4'($random(seed));
      ex = exp_status();
      fork
        u_host.page_read(16'($random(seed)), d0, d1);
        begin
          repeat (9) @(negedge i_ref_clk);
          busy = ~busy;
        end
      join
      check("live status", d0, ex);
      check("held status", d1, ex);
    end
    {busy, esusp, psusp, bulk} = 4'h0;
    for (int k = 0; k < 4; k++) begin
      u_host.clear_status();
      case (k)
        0: begin pulse(prog_err); err_code = 2'b01; end
        1: begin pulse(erase_err); err_code = 2'b10; end
        2: begin pulse(lock_hit); lock_f = 1'b1; end
        default: begin
          {busy, vpp_low} = 2'b11;
          repeat (4) @(negedge i_ref_clk);
          {busy, vpp_low, vpp_f} = 3'b001;
        end
      endcase
      read_status();
      {err_code, vpp_f, lock_f} = 4'h0;
    end
    u_host.clear_status();
    esusp = 1'b1;
    u_host.bus_write(16'h0000, flash_sr_pkg::CMD_LOCK_SETUP);
    u_host.bus_write(16'h0000, flash_sr_pkg::CMD_READ_ARRAY);
    err_code = 2'b11;
    read_status();
    {esusp, busy} = 2'b01;
    pulse(erase_err);
    busy = 1'b0;
    read_status();
    configure(16'h0000);
    configure(16'hffff);
    repeat (6) configure(16'($random(seed)));
    for (int j = 0; j < 4; j++) begin
      configure((16'($random(seed)) & 16'h3d00) | 16'h4048 | {13'h0000, bl_tab[j]});
      u_host.bus_write(16'h0000, flash_sr_pkg::CMD_READ_STATUS);
      u_host.burst_read(cfg[10], lat, waits, beats, w, rep);
      check("latency", 16'(lat), {12'h000, cfg[14:11]});
      check("wait edges", 16'(waits), 16'(cfg[14:11] - {3'h0, cfg[8]}));
      check("beats", 16'(beats), 16'(j == 3 ? 40 - cfg[14:11] : 4 << j));
      check("burst word", w, exp_status());
      check("word repeats", {15'h0000, rep}, 16'h0001);
    end
    @(negedge i_ref_clk) i_nrst = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    i_nrst = 1'b1;
    {err_code, cfg} = {2'b00, 16'hf94f};
    check("config after reset", read_cfg, cfg);
    read_status();
    close_out();
  end
endmodule
`default_nettype wire
